//--- verilog/rpsmi_cfg.sv
/*
 * Root port miscellaneous configuration and SMI/SCI event logic.
 * Holds the port configuration, event status and function disable words,
 * routes events to SCI/SMI, and supplies TLP intake hold-off and loopback address
 * translation. Assumes a simple config port: one-cycle read or write
 * strobe with byte offset, answered by a one-cycle ack the next cycle.
 * Event flags come from link, slot and root status logic on clk_sys.
 */
`timescale 1ns/10ps
module rpsmi_cfg (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic cfg_rd,
	input wire logic cfg_wr,
	input wire logic [7:0] cfg_addr,
	input wire logic [31:0] cfg_wdata,
	output logic [31:0] cfg_rdata,
	output logic cfg_ack,
	output logic cfg_unmapped,
	input wire logic common_clock_config,
	input wire logic slot_link_active_changed,
	input wire logic slot_presence_changed,
	input wire logic pme_msg_rcvd,
	input wire logic pme_sw_clear,
	input wire logic pm_int_req,
	input wire logic hotplug_int_req,
	input wire logic loopback_active,
	input wire logic [31:0] rx_addr_in,
	input wire logic tlp_valid_in,
	output logic tlp_ready,
	output logic [31:0] rx_addr_out,
	output logic [2:0] l0s_exit_latency,
	output logic root_pme_status,
	output logic pm_sci_req,
	output logic hotplug_sci_req,
	output logic sci_out,
	output logic smi_out_n,
	output logic func_disabled
);

	// ************************************************************
	// State
	// ************************************************************
	typedef struct packed {
		rpsmi_pkg::rpsmi_state_t fsm;
		logic [31:0] misc_cfg;
		logic [31:0] evt_sts;
		logic [31:0] func_dis;
		logic pme_sts;
		logic pme_pend;
		logic [31:0] rdata;
		logic unmapped;
		logic [31:0] xaddr;
		logic [2:0] lat;
		logic smi_n;
	} rpsmi_cfg_t;

	rpsmi_cfg_t st_q;
	rpsmi_cfg_t st_d;

	logic [2:0] rise;
	logic hp_smi_en;
	logic pm_smi_en;
	logic pm_sci_en;
	logic hp_sci_en;
	logic sel_misc;
	logic sel_sts;
	logic sel_dis;
	logic [31:0] w1c;
	logic [31:0] set_bits;

	// ************************************************************
	// Edge detection of event flags
	// ************************************************************
	rpsmi_edge u_edge (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.flag_in({st_q.pme_sts, slot_presence_changed, slot_link_active_changed}),
		.rise_out(rise)
	);

	// Enable fields of the configuration word
	assign pm_sci_en = st_q.misc_cfg[rpsmi_pkg::RPSMI_PM_SCI_EN_BIT];
	assign hp_sci_en = st_q.misc_cfg[rpsmi_pkg::RPSMI_HP_SCI_EN_BIT];
	assign hp_smi_en = st_q.misc_cfg[rpsmi_pkg::RPSMI_HP_SMI_EN_BIT];
	assign pm_smi_en = st_q.misc_cfg[rpsmi_pkg::RPSMI_PM_SMI_EN_BIT];

	// Address decode; disabled function hides its config space except the function disable word
	always_comb begin
		sel_misc = 1'b0;
		sel_sts = 1'b0;
		sel_dis = 1'b0;
		if (cfg_addr == rpsmi_pkg::RPSMI_OFF_FUNC_DIS) begin
			sel_dis = 1'b1;
		end else if (st_q.func_dis[rpsmi_pkg::RPSMI_DISABLE_BIT]) begin
			sel_misc = 1'b0;
		end else if (cfg_addr == rpsmi_pkg::RPSMI_OFF_MISC_CFG) begin
			sel_misc = 1'b1;
		end else if (cfg_addr == rpsmi_pkg::RPSMI_OFF_EVT_STS) begin
			sel_sts = 1'b1;
		end
	end

	// Hardware set terms for the status word
	always_comb begin
		set_bits = '0;
		set_bits[rpsmi_pkg::RPSMI_PM_SCI_STS_BIT] = pm_int_req & pm_sci_en;
		set_bits[rpsmi_pkg::RPSMI_HP_SCI_STS_BIT] = hotplug_int_req & hp_sci_en;
		set_bits[rpsmi_pkg::RPSMI_LINK_CHG_STS_BIT] = rise[0] & hp_smi_en;
		set_bits[rpsmi_pkg::RPSMI_PRES_CHG_STS_BIT] = rise[1] & hp_smi_en;
		set_bits[rpsmi_pkg::RPSMI_PM_SMI_STS_BIT] = rise[2] & pm_smi_en;
	end

	// Write-one-to-clear strobe for the status word
	assign w1c = (cfg_wr && sel_sts && st_q.fsm == rpsmi_pkg::RPSMI_ST_IDLE) ?
		(cfg_wdata & rpsmi_pkg::RPSMI_EVT_STS_MASK) : '0;

	// ************************************************************
	// Next state
	// ************************************************************
	always_comb begin
		st_d = st_q;
		// Set beats clear so an event in the clearing cycle is kept
		st_d.evt_sts = ((st_q.evt_sts & ~w1c) | set_bits) &
			rpsmi_pkg::RPSMI_EVT_STS_MASK;
		// Root PME status with a one-deep pending slot
		if (pme_sw_clear) begin
			st_d.pme_sts = st_q.pme_pend | pme_msg_rcvd;
			st_d.pme_pend = st_q.pme_pend & pme_msg_rcvd;
		end else if (pme_msg_rcvd) begin
			if (st_q.pme_sts) begin
				st_d.pme_pend = 1'b1;
			end else begin
				st_d.pme_sts = 1'b1;
			end
		end
		case (st_q.fsm)
			rpsmi_pkg::RPSMI_ST_IDLE: begin
				if (cfg_rd || cfg_wr) begin
					st_d.fsm = rpsmi_pkg::RPSMI_ST_ACK;
					st_d.unmapped = ~(sel_misc | sel_sts | sel_dis);
					st_d.rdata = '0;
					if (cfg_wr) begin
						if (sel_misc) begin
							st_d.misc_cfg = cfg_wdata & rpsmi_pkg::RPSMI_MISC_CFG_WMASK;
						end else if (sel_dis) begin
							st_d.func_dis = cfg_wdata & rpsmi_pkg::RPSMI_FUNC_DIS_WMASK;
						end
					end else begin
						// Reserved bits read as zero, masked on write
						if (sel_misc) begin
							st_d.rdata = st_q.misc_cfg;
						end else if (sel_sts) begin
							st_d.rdata = st_q.evt_sts;
						end else if (sel_dis) begin
							st_d.rdata = st_q.func_dis;
						end
					end
				end
			end
			rpsmi_pkg::RPSMI_ST_ACK: begin
				st_d.fsm = rpsmi_pkg::RPSMI_ST_IDLE;
			end
			default: begin
				st_d.fsm = rpsmi_pkg::RPSMI_ST_IDLE;
			end
		endcase
		// Address translator only acts in loopback
		st_d.xaddr = rx_addr_in;
		if (loopback_active && st_q.misc_cfg[rpsmi_pkg::RPSMI_XLATE_EN_BIT]) begin
			st_d.xaddr[rpsmi_pkg::RPSMI_ADDR_TOP_LSB +: 4] =
				rx_addr_in[rpsmi_pkg::RPSMI_ADDR_TOP_LSB +: 4] ^
				st_q.misc_cfg[rpsmi_pkg::RPSMI_AT_LSB +: 4];
		end
		// Exit latency picked by clock configuration
		if (common_clock_config) begin
			st_d.lat = st_q.misc_cfg[rpsmi_pkg::RPSMI_COMMON_CLK_EXIT_LATENCY_LSB +: 3];
		end else begin
			st_d.lat = st_q.misc_cfg[rpsmi_pkg::RPSMI_UNIQUE_CLK_EXIT_LATENCY_LSB +: 3];
		end
		// SMI follows the three SMI status bits of the next state
		st_d.smi_n = ~(st_d.evt_sts[rpsmi_pkg::RPSMI_LINK_CHG_STS_BIT] |
			st_d.evt_sts[rpsmi_pkg::RPSMI_PRES_CHG_STS_BIT] |
			st_d.evt_sts[rpsmi_pkg::RPSMI_PM_SMI_STS_BIT]);
	end

	// ************************************************************
	// Registers
	// ************************************************************
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			st_q.fsm <= rpsmi_pkg::RPSMI_ST_IDLE;
			st_q.misc_cfg <= rpsmi_pkg::RPSMI_MISC_CFG_RST;
			st_q.evt_sts <= rpsmi_pkg::RPSMI_EVT_STS_RST;
			st_q.func_dis <= rpsmi_pkg::RPSMI_FUNC_DIS_RST;
			st_q.pme_sts <= 1'b0;
			st_q.pme_pend <= 1'b0;
			st_q.rdata <= '0;
			st_q.unmapped <= 1'b0;
			st_q.xaddr <= '0;
			st_q.lat <= '0;
			st_q.smi_n <= 1'b1;
		end else begin
			st_q <= st_d;
		end
	end

	// ************************************************************
	// Outputs
	// ************************************************************
	assign cfg_ack = (st_q.fsm == rpsmi_pkg::RPSMI_ST_ACK);
	assign cfg_rdata = st_q.rdata;
	assign cfg_unmapped = cfg_ack & st_q.unmapped;
	// Hold-off and disable both stall TLP intake
	assign tlp_ready = ~st_q.misc_cfg[rpsmi_pkg::RPSMI_HOLD_OFF_BIT] &
		~st_q.func_dis[rpsmi_pkg::RPSMI_DISABLE_BIT];
	assign rx_addr_out = st_q.xaddr;
	assign l0s_exit_latency = st_q.lat;
	assign root_pme_status = st_q.pme_sts;
	assign pm_sci_req = st_q.evt_sts[rpsmi_pkg::RPSMI_PM_SCI_STS_BIT];
	assign hotplug_sci_req = st_q.evt_sts[rpsmi_pkg::RPSMI_HP_SCI_STS_BIT];
	assign sci_out = pm_sci_req | hotplug_sci_req;
	assign smi_out_n = st_q.smi_n;
	assign func_disabled = st_q.func_dis[rpsmi_pkg::RPSMI_DISABLE_BIT];

endmodule // rpsmi_cfg

//--- verilog/rpsmi_pkg.sv
/*
 * Package for the root port SMI/SCI configuration block: register offsets,
 * field positions, reset values and the config access state encoding.
 * Assumes 32-bit configuration words addressed by byte offset.
 */
package rpsmi_pkg;

	// ************************************************************
	// Register offsets
	// ************************************************************
	localparam logic [7:0] RPSMI_OFF_MISC_CFG = 8'hD8;
	localparam logic [7:0] RPSMI_OFF_EVT_STS = 8'hDC;
	localparam logic [7:0] RPSMI_OFF_FUNC_DIS = 8'hFC;

	// ************************************************************
	// Miscellaneous port configuration fields
	// ************************************************************
	localparam int RPSMI_PM_SCI_EN_BIT = 31;
	localparam int RPSMI_HP_SCI_EN_BIT = 30;
	localparam int RPSMI_HOLD_OFF_BIT = 29;
	localparam int RPSMI_XLATE_EN_BIT = 28;
	localparam int RPSMI_UNIQUE_CLK_EXIT_LATENCY_LSB = 18;
	localparam int RPSMI_COMMON_CLK_EXIT_LATENCY_LSB = 15;
	localparam int RPSMI_AT_LSB = 8;
	localparam int RPSMI_HP_SMI_EN_BIT = 1;
	localparam int RPSMI_PM_SMI_EN_BIT = 0;
	localparam int RPSMI_ADDR_TOP_LSB = 28;
	localparam logic [31:0] RPSMI_MISC_CFG_RST = 32'h0011_0000;
	// Writable bits: 31:28, 20:15, 14:12, 11:8, 1:0
	localparam logic [31:0] RPSMI_MISC_CFG_WMASK = 32'hF01F_FF03;

	// ************************************************************
	// Event status fields
	// ************************************************************
	localparam int RPSMI_PM_SCI_STS_BIT = 31;
	localparam int RPSMI_HP_SCI_STS_BIT = 30;
	localparam int RPSMI_LINK_CHG_STS_BIT = 4;
	localparam int RPSMI_PRES_CHG_STS_BIT = 1;
	localparam int RPSMI_PM_SMI_STS_BIT = 0;
	localparam logic [31:0] RPSMI_EVT_STS_RST = 32'h0000_0000;
	localparam logic [31:0] RPSMI_EVT_STS_MASK = 32'hC000_0013;

	// ************************************************************
	// Function disable fields
	// ************************************************************
	localparam int RPSMI_DISABLE_BIT = 0;
	localparam logic [31:0] RPSMI_FUNC_DIS_RST = 32'h0000_0000;
	localparam logic [31:0] RPSMI_FUNC_DIS_WMASK = 32'h0000_0005;

	// Config access sequencing
	typedef enum logic [1:0] {
		RPSMI_ST_IDLE = 2'b01,
		RPSMI_ST_ACK = 2'b10
	} rpsmi_state_t;

endpackage

//--- verilog/rpsmi_edge.sv
/*
 * Rising edge detector bank for the event flags feeding the status bits.
 * Assumes flag inputs are synchronous to clk_sys.
 */
`timescale 1ns/10ps
module rpsmi_edge (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic [2:0] flag_in,
	output logic [2:0] rise_out
);

	typedef struct packed {
		logic [2:0] prev;
	} rpsmi_edge_t;

	rpsmi_edge_t st_q;
	rpsmi_edge_t st_d;

	// Remember last level of every flag
	always_comb begin
		st_d = st_q;
		st_d.prev = flag_in;
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	// One pulse per bit on a 0-to-1 step
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_edge
			assign rise_out[gi] = flag_in[gi] & ~st_q.prev[gi];
		end
	endgenerate

endmodule // rpsmi_edge

//--- testbench/rpsmi_chk.sv
/* Port checker for rpsmi_cfg, attached by bind.
 * Assumes requests come as the config port contract allows. */
`timescale 1ns/10ps
module rpsmi_chk (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic cfg_rd,
	input wire logic cfg_wr,
	input wire logic [7:0] cfg_addr,
	input wire logic [31:0] cfg_wdata,
	input wire logic cfg_ack,
	input wire logic slot_link_active_changed,
	input wire logic slot_presence_changed,
	input wire logic pme_msg_rcvd,
	input wire logic pme_sw_clear,
	input wire logic pm_int_req,
	input wire logic hotplug_int_req,
	input wire logic loopback_active,
	input wire logic [31:0] rx_addr_in,
	input wire logic [31:0] rx_addr_out,
	input wire logic root_pme_status,
	input wire logic pm_sci_req,
	input wire logic hotplug_sci_req,
	input wire logic smi_out_n
);
	logic [31:0] misc_q;
	logic [1:0] qc_q;
	logic take, quiet, wsts, smi_src, pm_route, hp_route;
	logic [31:0] xaddr;
	// Shadow misc word; settle count hides the write-to-output lag
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			misc_q <= 32'h0011_0000;
			qc_q <= 2'h0;
		end else if (take) begin
			qc_q <= 2'h0;
			if (cfg_addr == 8'hD8)
				misc_q <= (cfg_wdata & 32'hF01F_FF03) | (misc_q & 32'h0FE0_00FC);
		end else if (qc_q != 2'h3)
			qc_q <= qc_q + 2'h1;
	end
	// Causes that outputs are tied to
	assign take = cfg_wr && !cfg_ack;
	assign quiet = qc_q == 2'h3;
	assign wsts = take && cfg_addr == 8'hDC;
	assign xaddr = rx_addr_in ^ {(misc_q[28] && loopback_active) ? misc_q[11:8] : 4'h0, 28'h0};
	assign smi_src = (misc_q[1] && (slot_link_active_changed || slot_presence_changed))
		|| (misc_q[0] && root_pme_status);
	assign pm_route = misc_q[31] && pm_int_req;
	assign hp_route = misc_q[30] && hotplug_int_req;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	a_ack_one_pulse:
		assert property ((cfg_rd || cfg_wr) && !cfg_ack |=> cfg_ack ##1 !cfg_ack) else $error("ack");
	a_addr_xlate_nibble:
		assert property (quiet |-> rx_addr_out == $past(xaddr)) else $error("xlate");
	a_hp_smi_set:
		assert property (misc_q[1] && ($rose(slot_link_active_changed) ||
			$rose(slot_presence_changed)) |-> ##[1:2] !smi_out_n) else $error("hp smi");
	a_pm_smi_set:
		assert property (misc_q[0] && $rose(root_pme_status) |-> ##[1:2] !smi_out_n)
			else $error("pm smi");
	a_smi_has_cause:
		assert property ($fell(smi_out_n) |-> $past(smi_src)) else $error("smi cause");
	a_smi_release_write:
		assert property ($rose(smi_out_n) |-> $past(wsts) || $past(wsts, 2)) else $error("smi release");
	a_pme_status_cause:
		assert property ($rose(root_pme_status) |-> $past(pme_msg_rcvd) || $past(pme_sw_clear))
			else $error("pme status");
	a_pm_sci_route:
		assert property ($rose(pm_sci_req) |-> $past(pm_route)) else $error("pm sci");
	a_hp_sci_route:
		assert property ($rose(hotplug_sci_req) |-> $past(hp_route)) else $error("hp sci");
	c_smi: cover property ($fell(smi_out_n));
	c_sci: cover property ($rose(pm_sci_req));
	c_pme: cover property ($rose(root_pme_status));
endmodule // rpsmi_chk
bind rpsmi_cfg rpsmi_chk u_chk (.*);

//--- testbench/rpsmi_pm_sink.sv
/* Platform power logic model: counts SMI and SCI assertions.
 * Assumes both lines are synchronous to clk_sys. */
`timescale 1ns/10ps
module rpsmi_pm_sink (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic smi_out_n,
	input wire logic sci_out,
	output int smi_cnt,
	output int sci_cnt
);
	logic smi_n_q, sci_q;
	// Level sink: counts each new assertion, never answers back
	always @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			smi_n_q <= 1'b1;
			sci_q <= 1'b0;
			smi_cnt <= 0;
			sci_cnt <= 0;
		end else begin
			smi_n_q <= smi_out_n;
			sci_q <= sci_out;
			if (smi_n_q && !smi_out_n)
				smi_cnt <= smi_cnt + 1;
			if (!sci_q && sci_out)
				sci_cnt <= sci_cnt + 1;
		end
	end
endmodule // rpsmi_pm_sink

//--- testbench/tb.sv
/* Self-checking bench for rpsmi_cfg with the power logic model.
 * Assumes the one-request-per-three-cycles config port pacing. */
`timescale 1ns/10ps
module tb;
	logic clk_sys = 0, nrst = 0, cfg_rd = 0, cfg_wr = 0, um, cfg_ack, cfg_unmapped, tlp_ready;
	logic [7:0] cfg_addr = 8'h00;
	logic [31:0] cfg_wdata = '0, rx_addr_in = '0, cfg_rdata, rx_addr_out, rd;
	logic common_clock_config = 0, slot_link_active_changed = 0, slot_presence_changed = 0;
	logic pme_msg_rcvd = 0, pme_sw_clear = 0, pm_int_req = 0, hotplug_int_req = 0;
	logic loopback_active = 0, tlp_valid_in = 0, root_pme_status, pm_sci_req;
	logic hotplug_sci_req, sci_out, smi_out_n, func_disabled;
	logic [2:0] l0s_exit_latency;
	logic [31:0] eb [3] = '{32'h10, 32'h2, 32'h1};
	int num_errors = 0, checked = 0, smi_cnt, sci_cnt, i;
	rpsmi_cfg DUT (.*);
	rpsmi_pm_sink PM (.*);
	always #50 clk_sys = ~clk_sys;
	task automatic report_and_stop;
		if (num_errors == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge clk_sys);
	endtask
	// One access, held through the ack edge so a refused repeat is harmless
	task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(negedge clk_sys);
		{cfg_wr, cfg_rd, cfg_addr, cfg_wdata} = {w, !w, a, d};
		@(negedge clk_sys);
		chk(cfg_ack, 1);
		{rd, um} = {cfg_rdata, cfg_unmapped};
		@(negedge clk_sys);
		{cfg_wr, cfg_rd} = 2'h0;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		acc(0, a, '0);
		chk(rd, e);
	endtask
	task automatic pme(input logic m, input logic c);
		{pme_msg_rcvd, pme_sw_clear} = {m, c};
		cyc(1);
		{pme_msg_rcvd, pme_sw_clear} = 2'h0;
		cyc(1);
	endtask
	// Flags held four cycles so a late status update still sees them
	task automatic pulse(input int s);
		{slot_link_active_changed, slot_presence_changed} = {s == 0, s == 1};
		pme(s == 2, 0);
		cyc(2);
		{slot_link_active_changed, slot_presence_changed} = 2'h0;
		pme(0, s == 2);
	endtask
	// Hang guard: tests need well under a thousand cycles
	initial begin
		repeat (3000) @(posedge clk_sys);
		num_errors++;
		report_and_stop;
	end
	initial begin
		cyc(12);
		nrst = 1;
		rdc(8'hD8, 32'h0011_0000);
		rdc(8'hDC, '0);
		rdc(8'hFC, '0);
		rdc(8'h40, '0);
		chk(um, 1);
		chk(l0s_exit_latency, 3'h4);
		common_clock_config = 1;
		cyc(2);
		chk(l0s_exit_latency, 3'h2);
		acc(1, 8'hD8, '1);
		rdc(8'hD8, 32'hF01F_FF03);
		{loopback_active, rx_addr_in} = {1'b1, 32'h1234_5678};
		cyc(2);
		chk(rx_addr_out, 32'hE234_5678);
		chk(tlp_ready, 0);
		chk(l0s_exit_latency, 3'h7);
		// Translator armed but loopback off: address passes untouched
		loopback_active = 0;
		cyc(2);
		chk(rx_addr_out, 32'h1234_5678);
		acc(1, 8'hD8, 32'h3);
		common_clock_config = 0;
		cyc(2);
		chk(rx_addr_out, 32'h1234_5678);
		chk(l0s_exit_latency, 3'h0);
		chk(tlp_ready, 1);
		// Each SMI source with its enable off, then on
		for (i = 0; i < 6; i++) begin
			acc(1, 8'hD8, (i < 3) ? 32'h0 : 32'h3);
			pulse(i % 3);
			chk(smi_out_n, i < 3);
			rdc(8'hDC, (i < 3) ? 32'h0 : eb[i % 3]);
			acc(1, 8'hDC, '0);
			chk(smi_out_n, i < 3);
			acc(1, 8'hDC, '1);
			chk(smi_out_n, 1);
		end
		chk(smi_cnt, 3);
		// Both interrupt needs raised; only the enabled one reaches SCI
		for (i = 0; i < 2; i++) begin
			acc(1, 8'hD8, 32'h8000_0000 >> i);
			{pm_int_req, hotplug_int_req} = 2'h3;
			cyc(2);
			{pm_int_req, hotplug_int_req} = 2'h0;
			chk(sci_out, 1);
			chk(pm_sci_req, i == 0);
			chk(hotplug_sci_req, i == 1);
			rdc(8'hDC, 32'h8000_0000 >> i);
			acc(1, 8'hDC, '1);
			chk(sci_out, 0);
		end
		chk(sci_cnt, 2);
		pme(1, 0);
		pme(1, 0);
		pme(0, 1);
		chk(root_pme_status, 1);
		pme(0, 1);
		chk(root_pme_status, 0);
		acc(1, 8'hFC, '1);
		chk(func_disabled, 1);
		chk(tlp_ready, 0);
		rdc(8'hD8, '0);
		chk(um, 1);
		rdc(8'hFC, 32'h5);
		acc(1, 8'hFC, '0);
		chk(tlp_ready, 1);
		// Mid-run reset with the function disabled must restore defaults
		acc(1, 8'hFC, 32'h1);
		nrst = 0;
		cyc(2);
		nrst = 1;
		rdc(8'hFC, '0);
		rdc(8'hD8, 32'h0011_0000);
		report_and_stop;
	end
endmodule // tb
